/* File: sarseq_pkg.sv */
/*
 * sarseq_pkg: constants shared by the conversion sequencer and its
 * input front end. Assumes a 100 MHz design clock that stands in for
 * the master clock input.
 */
package sarseq_pkg;

	// ==========================================================
	// variants and timing
	// ==========================================================
	localparam logic [1:0] SARSEQ_RES_12 = 2'h0;
	localparam logic [1:0] SARSEQ_RES_14 = 2'h1;
	localparam logic [1:0] SARSEQ_RES_16 = 2'h2;

	localparam int SARSEQ_CLK_NS = 10;
	localparam int SARSEQ_DIV = 4;
	localparam logic [1:0] SARSEQ_DIV_LAST = 2'(SARSEQ_DIV - 1);

	// least conversion length, master clock cycles
	localparam logic [7:0] SARSEQ_CONV_12 = 8'h31;
	localparam logic [7:0] SARSEQ_CONV_14 = 8'h39;
	localparam logic [7:0] SARSEQ_CONV_16 = 8'h41;
	// three cycles from the hold pin falling to the count starting, plus one
	// for the registered eoc; all four are taken off the length
	localparam logic [7:0] SARSEQ_CONV_SKIP = 8'h04;
	// end of conversion to end of track
	localparam logic [7:0] SARSEQ_TRACK_CYC = 8'h0f;
	// end of conversion strobe in standalone mode
	localparam logic [7:0] SARSEQ_EOC_HOLD_CYC = 8'h04;

	// calibration length after reset
	localparam int SARSEQ_CAL_FAST = 58280;
	localparam int SARSEQ_CAL_SLOW = 1441020;

	// least reset pulse width
	localparam int SARSEQ_RST_MIN_NS = 100;
	localparam int SARSEQ_RST_MIN_CYC =
		(SARSEQ_RST_MIN_NS + SARSEQ_CLK_NS - 1) / SARSEQ_CLK_NS;

	typedef enum logic [2:0] {
		SARSEQ_CAL,
		SARSEQ_TRACK,
		SARSEQ_WAIT_PHASE,
		SARSEQ_CONVERT
	} sarseq_state_t;

endpackage : sarseq_pkg

/* File: sarseq_if.sv */
/*
 * sarseq_if: synchronised host strobes carried from the front end to
 * the sequencer. Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface sarseq_if;
	logic rst_req;
	logic hold_fall;
	logic hold_low;
	logic cs_rise;
	logic soft_rst;
	logic rd_fall;
	logic cal_q;
	logic bg_cal_q;
	modport front (output rst_req, hold_fall, hold_low, cs_rise,
		soft_rst, rd_fall, cal_q, bg_cal_q);
	modport seq (input rst_req, hold_fall, hold_low, cs_rise,
		soft_rst, rd_fall, cal_q, bg_cal_q);
endinterface : sarseq_if

/* File: sarseq_front.sv */
/*
 * sarseq_front: synchronises host strobes, finds their edges and keeps
 * the calibration control latches. Assumes inputs are asynchronous.
 */
`timescale 1ns/100ps
module sarseq_front
	import sarseq_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_hold_n,
	input wire logic i_addr_bit0,
	input wire logic i_cal,
	input wire logic i_background_cal_ctrl_n,
	sarseq_if.front o_bus
);
	// ==========================================================
	// synchronisers
	// ==========================================================
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic [3:0] prev_q;
	logic cal_q;
	logic bg_q;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_q <= 4'hf;
			sync_q <= 4'hf;
			prev_q <= 4'hf;
		end
		else
		begin
			meta_q <= {i_addr_bit0, i_rd_n, i_hold_n, i_cs_n};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// control latches close as select returns high
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cal_q <= 1'b0;
			bg_q <= 1'b1;
		end
		else if (!sync_q[0])
		begin
			cal_q <= i_cal;
			bg_q <= i_background_cal_ctrl_n;
		end
	end

	assign o_bus.rst_req = 1'b0;
	assign o_bus.hold_fall = prev_q[1] & ~sync_q[1];
	assign o_bus.hold_low = ~sync_q[1];
	assign o_bus.cs_rise = ~prev_q[0] & sync_q[0];
	assign o_bus.soft_rst = ~sync_q[0] & ~sync_q[3] & ~sync_q[1];
	assign o_bus.rd_fall = ~sync_q[0] & prev_q[2] & ~sync_q[2];
	assign o_bus.cal_q = cal_q;
	assign o_bus.bg_cal_q = bg_q;
endmodule : sarseq_front

/* File: sarseq_top.sv */
/*
 * sarseq_top: conversion and calibration sequencer of a self-calibrating
 * successive-approximation converter. Assumes the host or loopback drives
 * hold; i_clk stands for the master clock.
 */
// Operation
// - control inputs latched on select release
// - internal clock is master divided four
// - async start waits up to four cycles
// - conversion lasts 49, 57 or 65 cycles
// - track done falls 15 after eoc
// - loopback gives fixed 64/72/80 period
// - reset aborts and starts fresh calibration
// - reset pulse 100 ns holds logic clear
// - calibration length follows reset release
// - select, addr0, hold low: software reset
// - eoc high during calibration, falls after
// - hold ignored while calibrating
// - standalone wide variants keep eoc high after calibration
// - hold fall starts conversion, auto track
// - eoc rises on read or new start
`timescale 1ns/100ps
module sarseq_top
	import sarseq_pkg::*;
#(
	parameter int CAL_FAST_CYC = SARSEQ_CAL_FAST,
	parameter int CAL_SLOW_CYC = SARSEQ_CAL_SLOW
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_hold_n,
	input wire logic i_addr_bit0,
	input wire logic i_cal,
	input wire logic i_background_cal_ctrl_n,
	input wire logic [1:0] i_resolution,
	input wire logic i_fast_grade,
	output logic o_eoc_n,
	output logic o_track_done_n,
	output logic o_tracking,
	output logic o_converting,
	output logic o_calibrating,
	output logic o_conv_clk,
	output logic o_cal_latched,
	output logic o_bg_cal_latched_n
);
	// ==========================================================
	// front end
	// ==========================================================
	sarseq_if bus ();

	sarseq_front u_front (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_cs_n(i_cs_n),
		.i_rd_n(i_rd_n),
		.i_hold_n(i_hold_n),
		.i_addr_bit0(i_addr_bit0),
		.i_cal(i_cal),
		.i_background_cal_ctrl_n(i_background_cal_ctrl_n),
		.o_bus(bus)
	);

	// ==========================================================
	// helpers
	// ==========================================================
	function automatic logic [7:0] conv_len(input logic [1:0] res);
		logic [7:0] n;
		n = SARSEQ_CONV_12;
		case (res)
			SARSEQ_RES_14: n = SARSEQ_CONV_14;
			SARSEQ_RES_16: n = SARSEQ_CONV_16;
			default: n = SARSEQ_CONV_12;
		endcase
		return n;
	endfunction : conv_len

	function automatic logic [20:0] cal_len(input logic [1:0] res,
		input logic fast);
		logic [20:0] n;
		n = 21'(CAL_SLOW_CYC - 1);
		if (res == SARSEQ_RES_12 && fast)
			n = 21'(CAL_FAST_CYC - 1);
		return n;
	endfunction : cal_len

	// ==========================================================
	// state
	// ==========================================================
	sarseq_state_t state_q;
	logic [1:0] div_q;
	logic [20:0] cnt_q;
	logic [7:0] trk_q;
	logic trk_run_q;
	logic eoc_n_q;
	logic [7:0] eoc_cnt_q;
	logic tdone_n_q;
	logic standalone;
	logic restart;

	assign standalone = ~i_cs_n & ~i_rd_n & i_addr_bit0;
	// software reset is a separate synchronous path, below hardware reset
	assign restart = bus.soft_rst;

	// conversion ends a fixed count after hold was seen: the phase wait
	// is absorbed, so loopback keeps a fixed period
	logic conv_end;
	assign conv_end = state_q == SARSEQ_CONVERT &&
		cnt_q[7:0] >= conv_len(i_resolution) - SARSEQ_CONV_SKIP;

	// divide by four; phase zero marks an internal clock edge
	// software reset leaves it running so the phase stays continuous
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			div_q <= 2'h0;
		else if (div_q == SARSEQ_DIV_LAST)
			div_q <= 2'h0;
		else
			div_q <= div_q + 2'h1;
	end

	// main sequence: calibrate, track, align, convert
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q <= SARSEQ_CAL;
			cnt_q <= 21'h0;
		end
		else if (restart)
		begin
			state_q <= SARSEQ_CAL;
			cnt_q <= 21'h0;
		end
		else
		begin
			case (state_q)
				SARSEQ_CAL:
				begin
					// hold is not looked at here
					if (cnt_q >= cal_len(i_resolution, i_fast_grade))
					begin
						state_q <= SARSEQ_TRACK;
						cnt_q <= 21'h0;
					end
					else
						cnt_q <= cnt_q + 21'h1;
				end
				SARSEQ_TRACK:
					if (bus.hold_fall)
					begin
						state_q <= SARSEQ_WAIT_PHASE;
						cnt_q <= 21'h0;
					end
				SARSEQ_WAIT_PHASE:
				begin
					// charge is already held; start waits for phase
					cnt_q <= cnt_q + 21'h1;
					if (div_q == SARSEQ_DIV_LAST)
						state_q <= SARSEQ_CONVERT;
				end
				SARSEQ_CONVERT:
					if (conv_end)
					begin
						state_q <= SARSEQ_TRACK;
						cnt_q <= 21'h0;
					end
					else
						cnt_q <= cnt_q + 21'h1;
				default:
					state_q <= SARSEQ_CAL;
			endcase
		end
	end

	// end of conversion: high in calibration, low when data valid
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			eoc_n_q <= 1'b1;
			eoc_cnt_q <= 8'h0;
		end
		else if (restart)
		begin
			eoc_n_q <= 1'b1;
			eoc_cnt_q <= 8'h0;
		end
		else if (state_q == SARSEQ_CAL)
		begin
			eoc_n_q <= 1'b1;
			if (cnt_q >= cal_len(i_resolution, i_fast_grade))
				// wide variants stay high in standalone
				eoc_n_q <= standalone &&
					i_resolution != SARSEQ_RES_12;
			eoc_cnt_q <= 8'h0;
		end
		else if (conv_end)
		begin
			eoc_n_q <= 1'b0;
			eoc_cnt_q <= 8'h0;
		end
		else if (state_q == SARSEQ_WAIT_PHASE)
			eoc_n_q <= 1'b1;
		else if (!eoc_n_q)
		begin
			// standalone reads are continuous: strobe of four
			if (bus.rd_fall ||
				(standalone && eoc_cnt_q >= SARSEQ_EOC_HOLD_CYC - 8'h1))
				eoc_n_q <= 1'b1;
			eoc_cnt_q <= eoc_cnt_q + 8'h1;
		end
	end

	// end of track: counts from eoc fall or calibration end in master clock cycles
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			trk_q <= 8'h0;
			trk_run_q <= 1'b0;
			tdone_n_q <= 1'b1;
		end
		else if (restart || state_q == SARSEQ_WAIT_PHASE)
		begin
			trk_q <= 8'h0;
			trk_run_q <= 1'b0;
			tdone_n_q <= 1'b1;
		end
		else if (state_q == SARSEQ_CONVERT)
		begin
			// arm the track count in the cycle eoc falls
			trk_q <= 8'h0;
			tdone_n_q <= 1'b1;
			trk_run_q <= conv_end;
		end
		else if (state_q == SARSEQ_CAL)
		begin
			trk_q <= 8'h0;
			tdone_n_q <= 1'b1;
			trk_run_q <= cnt_q >= cal_len(i_resolution, i_fast_grade);
		end
		else if (trk_run_q)
		begin
			trk_q <= trk_q + 8'h1;
			if (trk_q >= SARSEQ_TRACK_CYC - 8'h1)
			begin
				tdone_n_q <= 1'b0;
				trk_run_q <= 1'b0;
			end
		end
	end

	// loopback alignment: 15 from eoc keeps period fixed
	// conversion entry adds at most three phase cycles here
	always_comb
	begin
		o_converting = state_q == SARSEQ_CONVERT ||
			state_q == SARSEQ_WAIT_PHASE;
		o_tracking = state_q == SARSEQ_TRACK;
		o_calibrating = state_q == SARSEQ_CAL;
	end

	// track done comes straight from its register; it counts a fixed 15 clocks
	// from eoc, not the divider phase, so loopback sees no extra uncertainty
	assign o_eoc_n = eoc_n_q;
	assign o_track_done_n = tdone_n_q;
	assign o_conv_clk = div_q[1];
	assign o_cal_latched = bus.cal_q;
	assign o_bg_cal_latched_n = bus.bg_cal_q;
endmodule : sarseq_top

/* File: sarseq_top_props.sv */
/* sarseq_top_props: port checker for sarseq_top.
   assumes one clock and an async active high reset. */
`timescale 1ns/100ps
module sarseq_top_props
	import sarseq_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_hold_n,
	input wire logic i_addr_bit0,
	input wire logic [1:0] i_resolution,
	input wire logic o_eoc_n,
	input wire logic o_track_done_n,
	input wire logic o_tracking,
	input wire logic o_converting,
	input wire logic o_calibrating,
	input wire logic o_conv_clk,
	input wire logic o_cal_latched
);
	// ==========
	// helpers
	// ==========
	logic [7:0] cnt_q;
	logic [7:0] len;
	// least length of the selected variant
	assign len = i_resolution == SARSEQ_RES_16 ? SARSEQ_CONV_16 :
		i_resolution == SARSEQ_RES_14 ? SARSEQ_CONV_14 : SARSEQ_CONV_12;
	// cycles spent converting, cleared when idle
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
			cnt_q <= 8'h00;
		else
			cnt_q <= o_converting ? cnt_q + 8'h01 : 8'h00;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// ==========
	// properties
	// ==========
	property p_rst;
		$fell(i_rst) |-> o_calibrating && o_eoc_n;
	endproperty
	a_rst: assert property (p_rst) else $error("no cal");
	property p_cal;
		o_calibrating |-> o_eoc_n;
	endproperty
	a_cal: assert property (p_cal) else $error("eoc in cal");
	property p_trk;
		$fell(o_eoc_n) && !$past(o_calibrating, 2) |->
			##15 $fell(o_track_done_n);
	endproperty
	a_trk: assert property (p_trk) else $error("track time");
	// converting shows three cycles after the hold pin falls, so the
	// visible span is the length less those cycles, whatever the phase
	property p_len;
		$fell(o_converting) |-> cnt_q == len - 8'h03;
	endproperty
	a_len: assert property (p_len) else $error("conv len");
	property p_rd;
		!o_eoc_n && !i_cs_n && $fell(i_rd_n) |-> ##[1:4] o_eoc_n;
	endproperty
	a_rd: assert property (p_rd) else $error("eoc stuck");
	property p_div;
		$rose(o_conv_clk) |-> ##4 $rose(o_conv_clk);
	endproperty
	a_div: assert property (p_div) else $error("divider");
	property p_soft;
		(!i_cs_n && !i_addr_bit0 && !i_hold_n) [*3] |-> ##[0:2] o_calibrating;
	endproperty
	a_soft: assert property (p_soft) else $error("soft rst");
	property p_go;
		o_tracking && i_addr_bit0 && $fell(i_hold_n) |-> ##[1:4] o_converting;
	endproperty
	a_go: assert property (p_go) else $error("no start");
	property p_lat;
		i_cs_n [*5] |-> $stable(o_cal_latched);
	endproperty
	a_lat: assert property (p_lat) else $error("latch");
	c_eoc: cover property ($fell(o_eoc_n));
	c_cnv: cover property ($rose(o_converting));
	c_cal: cover property ($rose(o_calibrating));
endmodule : sarseq_top_props
bind sarseq_top sarseq_top_props i_props (.i_clk(i_clk), .i_rst(i_rst),
	.i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_hold_n(i_hold_n),
	.i_addr_bit0(i_addr_bit0), .i_resolution(i_resolution),
	.o_eoc_n(o_eoc_n), .o_track_done_n(o_track_done_n),
	.o_tracking(o_tracking), .o_converting(o_converting),
	.o_calibrating(o_calibrating), .o_conv_clk(o_conv_clk),
	.o_cal_latched(o_cal_latched));

/* File: sarseq_host.sv */
/* sarseq_host: host bus model with loopback wiring.
   assumes the sequencer samples on the rising edge. */
`timescale 1ns/100ps
module sarseq_host
(
	input wire logic i_clk,
	input wire logic i_track_done_n,
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_hold_n,
	output logic o_addr_bit0,
	output logic o_cal,
	output logic o_bgc_n
);
	logic hold_q = 1'b1;
	logic loop_q = 1'b0;
	// ==========
	// strobes
	// ==========
	// loopback gives a fixed throughput period
	assign o_hold_n = loop_q ? i_track_done_n : hold_q;
	// idle bus at time zero
	initial
	begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_addr_bit0 = 1'b1;
		o_cal = 1'b0;
		o_bgc_n = 1'b1;
	end
	// odd address write; hold low over one clock plus 60 ns
	task wr();
		@(negedge i_clk);
		o_cs_n = 1'b0;
		hold_q = 1'b0;
		repeat (7) @(negedge i_clk);
		hold_q = 1'b1;
		o_cs_n = 1'b1;
	endtask : wr
	task rd();
		@(negedge i_clk);
		o_cs_n = 1'b0;
		o_rd_n = 1'b0;
		repeat (2) @(negedge i_clk);
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
	endtask : rd
	// even address with hold low resets the sequencer
	task sr();
		@(negedge i_clk);
		o_addr_bit0 = 1'b0;
		o_cs_n = 1'b0;
		hold_q = 1'b0;
		repeat (4) @(negedge i_clk);
		hold_q = 1'b1;
		o_cs_n = 1'b1;
		o_addr_bit0 = 1'b1;
	endtask : sr
	// control inputs move only while deselected
	task ctl(input logic c, input logic b);
		@(negedge i_clk);
		o_cal = c;
		o_bgc_n = b;
	endtask : ctl
	task sa(input logic on);
		@(negedge i_clk);
		o_cs_n = !on;
		o_rd_n = !on;
		loop_q = on;
	endtask : sa
	// six clocks plus 2.25 us
	task acq();
		repeat (231) @(negedge i_clk);
	endtask : acq
endmodule : sarseq_host

/* File: sarseq_top_tb_top.sv */
/* sarseq_top_tb_top: bench for sarseq_top.
   assumes short calibration counts of 100 and 200 cycles. */
`timescale 1ns/100ps
module sarseq_top_tb_top
	import sarseq_pkg::*;
;
	logic i_clk, i_rst, fast, cs_n, rd_n, hold_n, a0, cal, bgc_n;
	logic eoc_n, td_n, trk, cnv, calg, cclk, cl, bl_n;
	logic [1:0] res;
	logic [7:0] lens [3] = '{SARSEQ_CONV_12, SARSEQ_CONV_14, SARSEQ_CONV_16};
	int pers [3] = '{64, 72, 80};
	int n_fail = 0;
	int check_count = 0;
	int t;
	realtime t0;
	// ==========
	// harness
	// ==========
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	sarseq_host i_host (.i_clk(i_clk), .i_track_done_n(td_n), .o_cs_n(cs_n),
		.o_rd_n(rd_n), .o_hold_n(hold_n), .o_addr_bit0(a0), .o_cal(cal),
		.o_bgc_n(bgc_n));
	sarseq_top #(.CAL_FAST_CYC(100), .CAL_SLOW_CYC(200)) i_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_rd_n(rd_n),
		.i_hold_n(hold_n), .i_addr_bit0(a0), .i_cal(cal),
		.i_background_cal_ctrl_n(bgc_n), .i_resolution(res),
		.i_fast_grade(fast), .o_eoc_n(eoc_n), .o_track_done_n(td_n),
		.o_tracking(trk), .o_converting(cnv), .o_calibrating(calg),
		.o_conv_clk(cclk), .o_cal_latched(cl), .o_bg_cal_latched_n(bl_n));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for end of conversion to reach a level
	task till(input logic v);
		t = 0;
		while (eoc_n !== v && t < 3000)
		begin
			@(negedge i_clk);
			t++;
		end
		if (t >= 3000)
			n_fail++;
	endtask : till
	task results();
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// ==========
	// tests
	// ==========
	initial
	begin
		i_rst = 1'b1;
		fast = 1'b1;
		res = SARSEQ_RES_12;
		repeat (10) @(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		chk({calg, eoc_n}, 2'h3);
		i_host.wr();
		chk(cnv, 1'b0);
		till(1'b0);
		chk(t + 9, 100);
		$display("test calibration done");
		for (int r = 0; r < 3; r++)
		begin
			res = 2'(r);
			i_host.acq();
			i_host.wr();
			till(1'b0);
			chk(t + 7, lens[r]);
			chk(trk, 1'b1);
			repeat (16) @(negedge i_clk);
			chk(td_n, 1'b0);
			chk(eoc_n, 1'b0);
			i_host.rd();
			repeat (3) @(negedge i_clk);
			chk(eoc_n, 1'b1);
		end
		$display("test conversion done");
		i_host.sa(1'b1);
		for (int r = 0; r < 3; r++)
		begin
			res = 2'(r);
			repeat (2) @(posedge cnv);
			t0 = $realtime;
			@(posedge cnv);
			chk(int'(($realtime - t0) / 10), pers[r]);
			@(negedge eoc_n);
			repeat (3) @(negedge i_clk);
			chk(eoc_n, 1'b0);
			repeat (2) @(negedge i_clk);
			chk(eoc_n, 1'b1);
		end
		i_host.sa(1'b0);
		$display("test loopback done");
		repeat (200) @(negedge i_clk);
		i_host.sr();
		chk(calg, 1'b1);
		till(1'b0);
		i_host.acq();
		i_host.wr();
		repeat (10) @(negedge i_clk);
		chk(cnv, 1'b1);
		i_rst = 1'b1;
		repeat (10) @(negedge i_clk);
		chk({calg, eoc_n, td_n}, 3'h7);
		i_rst = 1'b0;
		@(negedge i_clk);
		chk({calg, cnv}, 2'h2);
		till(1'b0);
		$display("test reset done");
		i_host.ctl(1'b1, 1'b0);
		repeat (5) @(negedge i_clk);
		chk(cl, 1'b0);
		i_host.rd();
		repeat (5) @(negedge i_clk);
		chk({cl, bl_n}, 2'h2);
		$display("test latch done");
		results();
	end
	// the tests need about 26 us
	initial
	begin
		#200000;
		n_fail++;
		results();
	end
endmodule : sarseq_top_tb_top
